// File: inc/gpio_pin_routing_pkg.sv
// constants and types shared by the gpio pin routing block
package gpio_pin_routing_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_ROUTING_CTL = 16'hC006;
    localparam logic [15:0] IDX_LOW_OUT = 16'hC01E;
    localparam logic [15:0] IDX_LOW_IN = 16'hC020;
    localparam logic [15:0] IDX_LOW_DIR = 16'hC022;
    localparam logic [15:0] IDX_HIGH_OUT = 16'hC024;
    localparam logic [15:0] IDX_HIGH_IN = 16'hC026;
    localparam logic [15:0] IDX_HIGH_DIR = 16'hC028;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hC0F0;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hC0F2;
    localparam int ADDR_W = 18;

    // routing control field positions
    localparam int BIT_WPROT = 15;
    localparam int BIT_TXEN_ROUTE = 14;
    localparam int BIT_ALT_SS = 11;
    localparam int MODE_LSB = 8;
    localparam int BIT_FS_GPIO = 7;
    localparam int BIT_FS_XD = 6;
    localparam int BIT_SPI_GPIO = 5;
    localparam int BIT_SPI_XD = 4;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_1_POL = 3;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_1_EN = 2;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_0_POL = 1;
    localparam int BIT_EXTERNAL_INTERRUPT_LINE_0_EN = 0;
    localparam logic [15:0] CTL_WRITABLE = 16'hCFFF;
    localparam logic [15:0] CTL_LOCKED = 16'hFF00;

    // pin positions
    localparam int PIN_TXEN = 30;
    localparam int PIN_EXTERNAL_INTERRUPT_LINE_1 = 25;
    localparam int PIN_EXTERNAL_INTERRUPT_LINE_0 = 24;
    localparam int PIN_ALT_SS = 15;
    localparam int PIN_SPI_BASE = 8;
    localparam int SPI_SS_IDX = 1;
    localparam int XD_SPI_BASE = 8;
    localparam int XD_FS_BASE = 12;

    // reset values
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [31:0] PORT_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_GPIO = 3'h0,
        MODE_IDE = 3'h4,
        MODE_HOST_PORT = 3'h5,
        MODE_SCAN = 3'h6
    } pin_mode_t;

endpackage

// File: rtl/gpio_pin_routing_control.sv
// gpio pin routing control: shared pin ownership, data/direction registers, edge interrupts
// Notes on behaviour
// - once the write-protect bit 15 is set, bits 15:8 of the routing control ignore writes until reset.
// - bit 14 drives the usb transmitter enable status onto pin 30, otherwise pin 30 is left alone.
// - with spi on gpio, bit 11 moves spi_slave_select_n from pin 9 to pin 15.
// - bits 10:8 give pins 15:0 and 24:19 to gpio (000), ide (100), host_port_interface (101) or scan (110).
// - bit 7 with bit 6 clear puts the fast_serial_port on pins 26 and 18:16.
// - bit 6 puts the fast_serial_port on external_memory_data_bus bits 15:12 and wins over bit 7.
// - bit 5 with bit 4 clear puts the spi port on pins 11:8, else those pins stay free.
// - bit 4 puts the spi port on external_memory_data_bus bits 11:8 and wins over bits 5 and 11.
// - bit 3 picks the rising (1) or falling (0) edge for external_interrupt_line_1.
// - external_interrupt_line_1 is sensed on pin 25 and external_interrupt_line_0 on pin 24.
// - bits 2 and 0 enable lines 1 and 0 only together with the outside gpio interrupt enable.
// - bit 1 picks the rising (1) or falling (0) edge for external_interrupt_line_0.
// - output data registers read back what was written, not the pin levels.
// - a direction bit of 1 makes its pin an output, 0 an input; low covers 15:0, high 31:16.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_routing_control
    import gpio_pin_routing_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [gpio_pin_routing_pkg::ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic irq,
    input wire logic gpioIrqEnable,
    input wire logic usbTxEn,
    input wire logic [31:0] gpioIn,
    output logic [31:0] gpioOut,
    output logic [31:0] gpioOe,
    input wire logic [3:0] fsOut,
    input wire logic [3:0] fsOe,
    output logic [3:0] fsIn,
    input wire logic [3:0] spiOut,
    input wire logic [3:0] spiOe,
    output logic [3:0] spiIn,
    input wire logic [21:0] altOut,
    input wire logic [21:0] altOe,
    output logic [21:0] altIn,
    output logic [2:0] pinMode,
    input wire logic [15:0] memXdOut,
    input wire logic [15:0] memXdOe,
    output logic [15:0] memXdIn,
    input wire logic [15:0] xdPinIn,
    output logic [15:0] xdPinOut,
    output logic [15:0] xdPinOe
);
    import gpio_pin_routing_pkg::*;

    logic [15:0] ctl_ff, nxt_ctl;
    logic [31:0] outData_ff, nxt_outData;
    logic [31:0] dir_ff, nxt_dir;
    logic [1:0] status_ff, nxt_status;
    logic [1:0] mask_ff, nxt_mask;
    logic ack_ff, nxt_ack;
    logic [15:0] readData_ff, nxt_readData;
    logic [31:0] syncA_ff, syncB_ff, syncC_ff, stable_ff;
    logic [31:0] nxt_stable;
    logic [15:0] regIdx, regValue;
    logic regHit, busReq, wrDone;
    logic [15:0] wrMask, wrData;
    logic [1:0] edgeEvent;
    logic fsGpio, fsXd, spiGpio, spiXd, altSs, altMode;
    logic [31:0] periphSel, periphOut, periphOe;

    // bus decode: word aligned, low address bits ignored
    always_comb
    begin
        regIdx = avsAddress[ADDR_W-1:2];
        busReq = avsRead | avsWrite;
        wrDone = avsWrite & ack_ff;
        wrMask = {{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
        wrData = avsWriteData[15:0];
        avsWaitRequest = busReq & ~ack_ff;
        avsReadData = {16'h0000, readData_ff};
        irq = |(status_ff & mask_ff);
        pinMode = ctl_ff[MODE_LSB+2:MODE_LSB];
    end

    // one wait cycle per access; read data is sampled in the first cycle and then held
    always_comb
    begin
        nxt_ack = busReq & ~ack_ff;
        nxt_readData = readData_ff;
        regValue = 16'h0000;
        regHit = 1'b1;
        case (regIdx)
            IDX_ROUTING_CTL: regValue = ctl_ff;
            IDX_LOW_OUT: regValue = outData_ff[15:0];
            IDX_HIGH_OUT: regValue = outData_ff[31:16];
            IDX_LOW_IN: regValue = stable_ff[15:0];
            IDX_HIGH_IN: regValue = stable_ff[31:16];
            IDX_LOW_DIR: regValue = dir_ff[15:0];
            IDX_HIGH_DIR: regValue = dir_ff[31:16];
            IDX_IRQ_STATUS: regValue = {14'h0000, status_ff};
            IDX_IRQ_MASK: regValue = {14'h0000, mask_ff};
            default: regHit = 1'b0;
        endcase
        if (avsRead & ~ack_ff)
        begin
            nxt_readData = regHit ? regValue : 16'h0000;
        end
    end

    // register writes, with byte lanes honoured
    always_comb
    begin
        nxt_ctl = ctl_ff;
        nxt_outData = outData_ff;
        nxt_dir = dir_ff;
        nxt_mask = mask_ff;
        if (wrDone)
        begin
            case (regIdx)
                IDX_ROUTING_CTL:
                begin
                    if (ctl_ff[BIT_WPROT])
                    begin
                        nxt_ctl = (ctl_ff & ~(wrMask & CTL_WRITABLE & ~CTL_LOCKED))
                            | (wrData & wrMask & CTL_WRITABLE & ~CTL_LOCKED);
                    end
                    else
                    begin
                        nxt_ctl = (ctl_ff & ~(wrMask & CTL_WRITABLE))
                            | (wrData & wrMask & CTL_WRITABLE);
                    end
                end
                IDX_LOW_OUT: nxt_outData[15:0] = (outData_ff[15:0] & ~wrMask) | (wrData & wrMask);
                IDX_HIGH_OUT: nxt_outData[31:16] = (outData_ff[31:16] & ~wrMask) | (wrData & wrMask);
                IDX_LOW_DIR: nxt_dir[15:0] = (dir_ff[15:0] & ~wrMask) | (wrData & wrMask);
                IDX_HIGH_DIR: nxt_dir[31:16] = (dir_ff[31:16] & ~wrMask) | (wrData & wrMask);
                IDX_IRQ_MASK:
                begin
                    if (avsByteEnable[0])
                    begin
                        nxt_mask = wrData[1:0];
                    end
                end
                default:
                begin
                    nxt_mask = mask_ff;
                end
            endcase
        end
    end

    // pin filter: a level counts once the last two stages agree
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            nxt_stable[i] = (syncB_ff[i] == syncC_ff[i]) ? syncC_ff[i] : stable_ff[i];
        end
    end

    // edge detection on the filtered interrupt pins
    always_comb
    begin
        // line 1 on pin 25, line 0 on pin 24
        edgeEvent[1] = ctl_ff[BIT_EXTERNAL_INTERRUPT_LINE_1_POL]
            ? (nxt_stable[PIN_EXTERNAL_INTERRUPT_LINE_1] & ~stable_ff[PIN_EXTERNAL_INTERRUPT_LINE_1])
            : (~nxt_stable[PIN_EXTERNAL_INTERRUPT_LINE_1] & stable_ff[PIN_EXTERNAL_INTERRUPT_LINE_1]);
        edgeEvent[0] = ctl_ff[BIT_EXTERNAL_INTERRUPT_LINE_0_POL]
            ? (nxt_stable[PIN_EXTERNAL_INTERRUPT_LINE_0] & ~stable_ff[PIN_EXTERNAL_INTERRUPT_LINE_0])
            : (~nxt_stable[PIN_EXTERNAL_INTERRUPT_LINE_0] & stable_ff[PIN_EXTERNAL_INTERRUPT_LINE_0]);
        edgeEvent = edgeEvent & {ctl_ff[BIT_EXTERNAL_INTERRUPT_LINE_1_EN], ctl_ff[BIT_EXTERNAL_INTERRUPT_LINE_0_EN]}
            & {2{gpioIrqEnable}};
        // write one to clear; a new event in the same cycle wins
        nxt_status = status_ff;
        if (wrDone && regIdx == IDX_IRQ_STATUS && avsByteEnable[0])
        begin
            nxt_status = status_ff & ~wrData[1:0];
        end
        nxt_status = nxt_status | edgeEvent;
    end

    // pin ownership: plain gpio lowest, alternate mode next, fast serial and spi highest
    always_comb
    begin
        fsXd = ctl_ff[BIT_FS_XD];
        fsGpio = ctl_ff[BIT_FS_GPIO] & ~fsXd;
        spiXd = ctl_ff[BIT_SPI_XD];
        spiGpio = ctl_ff[BIT_SPI_GPIO] & ~spiXd;
        altSs = spiGpio & ctl_ff[BIT_ALT_SS];
        // reserved codes fall back to plain gpio
        altMode = (pinMode == MODE_IDE) || (pinMode == MODE_HOST_PORT)
            || (pinMode == MODE_SCAN);
        periphSel = 32'h0000_0000;
        periphOut = 32'h0000_0000;
        periphOe = 32'h0000_0000;
        altIn = {gpioIn[24:19], gpioIn[15:0]};
        if (altMode)
        begin
            periphSel[15:0] = 16'hFFFF;
            periphSel[24:19] = 6'h3F;
            periphOut[15:0] = altOut[15:0];
            periphOut[24:19] = altOut[21:16];
            periphOe[15:0] = altOe[15:0];
            periphOe[24:19] = altOe[21:16];
        end
        if (fsGpio)
        begin
            periphSel[18:16] = 3'h7;
            periphSel[26] = 1'b1;
            periphOut[18:16] = fsOut[2:0];
            periphOut[26] = fsOut[3];
            periphOe[18:16] = fsOe[2:0];
            periphOe[26] = fsOe[3];
        end
        if (spiGpio)
        begin
            periphSel[PIN_SPI_BASE+:4] = 4'hF;
            periphOut[PIN_SPI_BASE+:4] = spiOut;
            periphOe[PIN_SPI_BASE+:4] = spiOe;
            if (altSs)
            begin
                // pin 9 goes back to its other owner
                periphSel[PIN_SPI_BASE+SPI_SS_IDX] = altMode;
                periphOut[PIN_SPI_BASE+SPI_SS_IDX] = altMode ? altOut[PIN_SPI_BASE+SPI_SS_IDX] : 1'b0;
                periphOe[PIN_SPI_BASE+SPI_SS_IDX] = altMode ? altOe[PIN_SPI_BASE+SPI_SS_IDX] : 1'b0;
                periphSel[PIN_ALT_SS] = 1'b1;
                periphOut[PIN_ALT_SS] = spiOut[SPI_SS_IDX];
                periphOe[PIN_ALT_SS] = spiOe[SPI_SS_IDX];
            end
        end
        if (ctl_ff[BIT_TXEN_ROUTE])
        begin
            periphSel[PIN_TXEN] = 1'b1;
            periphOut[PIN_TXEN] = usbTxEn;
            periphOe[PIN_TXEN] = 1'b1;
        end
        // peripheral inputs pass raw; each receiver synchronises its own inputs
        fsIn = fsXd ? xdPinIn[XD_FS_BASE+:4] : {gpioIn[26], gpioIn[18:16]};
        spiIn = spiXd ? xdPinIn[XD_SPI_BASE+:4] : gpioIn[PIN_SPI_BASE+:4];
        if (altSs)
        begin
            spiIn[SPI_SS_IDX] = gpioIn[PIN_ALT_SS];
        end
        memXdIn = xdPinIn;
        xdPinOut = memXdOut;
        xdPinOe = memXdOe;
        if (fsXd)
        begin
            xdPinOut[XD_FS_BASE+:4] = fsOut;
            xdPinOe[XD_FS_BASE+:4] = fsOe;
        end
        if (spiXd)
        begin
            xdPinOut[XD_SPI_BASE+:4] = spiOut;
            xdPinOe[XD_SPI_BASE+:4] = spiOe;
        end
    end

    // final per-pin mux
    genvar p;
    generate
        for (p = 0; p < 32; p++)
        begin : g_pin
            assign gpioOut[p] = periphSel[p] ? periphOut[p] : outData_ff[p];
            assign gpioOe[p] = periphSel[p] ? periphOe[p] : dir_ff[p];
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctl_ff <= CTL_RESET;
            outData_ff <= PORT_RESET;
            dir_ff <= PORT_RESET;
            status_ff <= 2'h0;
            mask_ff <= 2'h0;
            ack_ff <= 1'b0;
            readData_ff <= 16'h0000;
            syncA_ff <= PORT_RESET;
            syncB_ff <= PORT_RESET;
            syncC_ff <= PORT_RESET;
            stable_ff <= PORT_RESET;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            outData_ff <= nxt_outData;
            dir_ff <= nxt_dir;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            ack_ff <= nxt_ack;
            readData_ff <= nxt_readData;
            syncA_ff <= gpioIn;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
            stable_ff <= nxt_stable;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    wp_lock_a: assert property ((ctl_ff[BIT_WPROT] && wrDone) |=> $stable(ctl_ff[15:8]))
        else $error("protected mode bits changed");
    ud_route_a: assert property (ctl_ff[BIT_TXEN_ROUTE] |-> (gpioOut[30] == usbTxEn && gpioOe[30]))
        else $error("transmitter enable not on pin 30");
    sas_move_a: assert property ((spiGpio && ctl_ff[BIT_ALT_SS]) |-> gpioOut[15] == spiOut[1]
        && gpioOe[15] == spiOe[1]) else $error("slave select not moved to pin 15");
    alt_mode_a: assert property ((pinMode == MODE_HOST_PORT && !ctl_ff[BIT_TXEN_ROUTE])
        |-> gpioOe[20] == altOe[17] && gpioOut[0] == altOut[0]) else $error("alternate mode pins");
    fs_gpio_a: assert property ((ctl_ff[7:6] == 2'b10) |-> gpioOut[26] == fsOut[3]
        && gpioOut[16] == fsOut[0]) else $error("fast serial not on gpio");
    fs_xd_a: assert property (ctl_ff[BIT_FS_XD] |-> xdPinOe[15:12] == fsOe
        && fsIn == xdPinIn[15:12]) else $error("fast serial not on external bus");
    spi_gpio_a: assert property ((ctl_ff[5:4] == 2'b10 && !ctl_ff[11]) |-> gpioOut[11:8] == spiOut)
        else $error("spi not on gpio");
    spi_xd_a: assert property (ctl_ff[BIT_SPI_XD] |-> xdPinOut[11:8] == spiOut)
        else $error("spi not on external bus");
    external_interrupt_line_1_edge_a: assert property ((ctl_ff[3:2] == 2'b11 && gpioIrqEnable
        && !stable_ff[25] && nxt_stable[25]) |=> status_ff[1]) else $error("line 1 edge lost");
    external_interrupt_line_0_edge_a: assert property ((ctl_ff[1:0] == 2'b01 && gpioIrqEnable
        && stable_ff[24] && !nxt_stable[24]) |=> status_ff[0]) else $error("line 0 edge lost");
    irq_gate_a: assert property ((!gpioIrqEnable && !wrDone) |=> status_ff == $past(status_ff))
        else $error("event without outside enable");
    readback_a: assert property ((wrDone && regIdx == IDX_LOW_OUT && avsByteEnable[1:0] == 2'b11)
        |=> outData_ff[15:0] == $past(wrData)) else $error("output data not stored");
    dir_pin_a: assert property ((ctl_ff == 16'h0000) |-> gpioOe == dir_ff && gpioOut == outData_ff)
        else $error("direction not applied");
    bus_answer_a: assert property (busReq |-> ##[0:1] !avsWaitRequest)
        else $error("bus not answered");

endmodule

`default_nettype wire

// File: sim/pin_farside.sv
// far side of the shared pins: drives the bench's chosen level on any pin the block releases
`timescale 1ns/1ps
`default_nettype none

module pin_farside (
    input wire logic [31:0] gpioOut,
    input wire logic [31:0] gpioOe,
    input wire logic [15:0] xdPinOut,
    input wire logic [15:0] xdPinOe,
    input wire logic [31:0] extLevel,
    input wire logic [15:0] extXd,
    output logic [31:0] gpioIn,
    output logic [15:0] xdPinIn
);
    assign gpioIn = (gpioOut & gpioOe) | (extLevel & ~gpioOe);
    assign xdPinIn = (xdPinOut & xdPinOe) | (extXd & ~xdPinOe);
endmodule

`default_nettype wire

// File: sim/gpio_pin_routing_control_tb.sv
// self-checking bench for the gpio pin routing block
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_routing_control_tb;
    import gpio_pin_routing_pkg::*;
    logic core_clk, reset, avsRead, avsWrite, avsWaitRequest, irq, gpioIrqEnable, usbTxEn;
    logic [ADDR_W-1:0] avsAddress;
    logic [31:0] avsWriteData, avsReadData, gpioIn, gpioOut, gpioOe, extLevel;
    logic [3:0] avsByteEnable, fsOut, fsOe, fsIn, spiOut, spiOe, spiIn;
    logic [21:0] altOut, altOe, altIn;
    logic [2:0] pinMode;
    logic [15:0] memXdOut, memXdOe, memXdIn, xdPinIn, xdPinOut, xdPinOe, extXd;
    logic [15:0] idxs[8] = '{IDX_ROUTING_CTL, IDX_LOW_OUT, IDX_LOW_IN, IDX_LOW_DIR,
        IDX_HIGH_OUT, IDX_HIGH_IN, IDX_HIGH_DIR, 16'hC0FE};
    int n_errors, comparisons, m;

    gpio_pin_routing_control uut (.core_clk(core_clk), .reset(reset),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .irq(irq),
        .gpioIrqEnable(gpioIrqEnable), .usbTxEn(usbTxEn), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .fsOut(fsOut), .fsOe(fsOe), .fsIn(fsIn),
        .spiOut(spiOut), .spiOe(spiOe), .spiIn(spiIn), .altOut(altOut), .altOe(altOe),
        .altIn(altIn), .pinMode(pinMode), .memXdOut(memXdOut), .memXdOe(memXdOe),
        .memXdIn(memXdIn), .xdPinIn(xdPinIn), .xdPinOut(xdPinOut), .xdPinOe(xdPinOe));

    pin_farside far (.gpioOut(gpioOut), .gpioOe(gpioOe), .xdPinOut(xdPinOut),
        .xdPinOe(xdPinOe), .extLevel(extLevel), .extXd(extXd), .gpioIn(gpioIn),
        .xdPinIn(xdPinIn));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [15:0] idx, input logic rw, input logic [15:0] d);
        @(posedge core_clk);
        avsAddress <= {idx, 2'b00};
        avsWriteData <= {16'h0000, d};
        avsWrite <= rw;
        avsRead <= ~rw;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do
        begin
            @(posedge core_clk);
        end
        while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [15:0] exp);
        bus(idx, 1'b0, 16'h0000);
        chk(avsReadData, {16'h0000, exp});
    endtask

    task automatic pin(input int p, input logic v);
        @(posedge core_clk);
        extLevel[p] <= v;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic do_reset;
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
    endtask

    initial
    begin
        #100000;
        n_errors++;
        report_and_stop;
    end

    initial
    begin
        {reset, avsRead, avsWrite, gpioIrqEnable, usbTxEn} = 5'b10000;
        avsAddress = '0;
        avsWriteData = '0;
        avsByteEnable = 4'h3;
        {extLevel, extXd, fsOut, fsOe, spiOut, spiOe, altOut, altOe} = '0;
        memXdOut = 16'h00C3;
        memXdOe = 16'h00FF;
        do_reset;
        // register reset values, unmapped word reads zero
        foreach (idxs[i]) rdc(idxs[i], 16'h0000);
        wr(IDX_LOW_OUT, 16'hA5A5);
        wr(IDX_LOW_DIR, 16'h00FF);
        #1 chk(gpioOe, 32'h0000_00FF);
        chk(gpioOut & gpioOe, 32'h0000_00A5);
        @(posedge core_clk);
        extLevel <= 32'h5A5A_3C3C;
        repeat (6) @(posedge core_clk);
        rdc(IDX_LOW_IN, 16'h3CA5);
        rdc(IDX_HIGH_IN, 16'h5A5A);
        rdc(IDX_LOW_OUT, 16'hA5A5);
        usbTxEn <= 1'b1;
        #1 chk(32'(gpioOut[30] & gpioOe[30]), 32'h0);
        wr(IDX_ROUTING_CTL, 16'h4000);
        #1 chk(32'(gpioOut[30] & gpioOe[30]), 32'h1);
        @(posedge core_clk);
        usbTxEn <= 1'b0;
        spiOut <= 4'hA;
        spiOe <= 4'hF;
        fsOut <= 4'h9;
        fsOe <= 4'hF;
        #1 chk(32'(gpioOut[30]), 32'h0);
        wr(IDX_ROUTING_CTL, 16'h0020);
        #1 chk(32'({gpioOe[11:8], gpioOut[11:8]}), 32'hFA);
        chk(32'(spiIn), 32'hA);
        wr(IDX_ROUTING_CTL, 16'h0820);
        #1 chk(32'({gpioOe[15], gpioOut[15], gpioOe[9]}), 32'h6);
        wr(IDX_ROUTING_CTL, 16'h0830);
        #1 chk(32'({xdPinOe[11:8], xdPinOut[11:8]}), 32'hFA);
        chk(32'({gpioOe[15], gpioOe[11:8]}), 32'h0);
        chk(32'(xdPinOut[7:0] & xdPinOe[7:0]), 32'hC3);
        chk(32'(memXdIn), 32'h0AC3);
        wr(IDX_ROUTING_CTL, 16'h0080);
        #1 chk(32'({gpioOe[26], gpioOe[18:16], gpioOut[26], gpioOut[18:16]}), 32'hF9);
        chk(32'(fsIn), 32'h9);
        wr(IDX_ROUTING_CTL, 16'h00C0);
        #1 chk(32'({xdPinOe[15:12], xdPinOut[15:12]}), 32'hF9);
        chk(32'({gpioOe[26], gpioOe[18:16]}), 32'h0);
        @(posedge core_clk);
        altOut <= 22'h2A_5A5A;
        altOe <= 22'h3F_FFFF;
        for (m = 4; m < 7; m++)
        begin
            wr(IDX_ROUTING_CTL, 16'(m << 8));
            #1 chk(32'(pinMode), m);
            chk(32'({gpioOe[24:19], gpioOe[15:0]}), 32'h3F_FFFF);
            chk(32'({gpioOut[24:19], gpioOut[15:0]}), 32'h2A_5A5A);
            chk(32'(altIn), 32'h2A_5A5A);
        end
        wr(IDX_ROUTING_CTL, 16'h0100);
        #1 chk(gpioOe & 32'h01F8_FFFF, 32'h0000_00FF);
        @(posedge core_clk);
        altOe <= '0;
        extLevel <= '0;
        gpioIrqEnable <= 1'b1;
        wr(IDX_ROUTING_CTL, 16'h000D);
        wr(IDX_IRQ_MASK, 16'h0003);
        repeat (6) @(posedge core_clk);
        wr(IDX_IRQ_STATUS, 16'h0003);
        pin(25, 1'b1);
        rdc(IDX_IRQ_STATUS, 16'h0002);
        chk(32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 16'h0002);
        #1 chk(32'(irq), 32'h0);
        pin(25, 1'b0);
        pin(24, 1'b1);
        rdc(IDX_IRQ_STATUS, 16'h0000);
        pin(24, 1'b0);
        rdc(IDX_IRQ_STATUS, 16'h0001);
        wr(IDX_IRQ_MASK, 16'h0000);
        #1 chk(32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 16'h0003);
        #1 chk(32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 16'h0001);
        gpioIrqEnable <= 1'b0;
        pin(25, 1'b1);
        rdc(IDX_IRQ_STATUS, 16'h0000);
        gpioIrqEnable <= 1'b1;
        wr(IDX_ROUTING_CTL, 16'h0009);
        pin(25, 1'b0);
        pin(25, 1'b1);
        rdc(IDX_IRQ_STATUS, 16'h0000);
        // reserved bits 13:12 never stick
        wr(IDX_ROUTING_CTL, 16'h3000);
        rdc(IDX_ROUTING_CTL, 16'h0000);
        wr(IDX_ROUTING_CTL, 16'h8400);
        wr(IDX_ROUTING_CTL, 16'h00FF);
        rdc(IDX_ROUTING_CTL, 16'h84FF);
        chk(32'(pinMode), 32'h4);
        do_reset;
        wr(IDX_ROUTING_CTL, 16'h0100);
        rdc(IDX_ROUTING_CTL, 16'h0100);
        report_and_stop;
    end
endmodule

`default_nettype wire
